// ==== src/i2c_fw_params.svh ====
`ifndef I2C_FW_PARAMS_SVH
`define I2C_FW_PARAMS_SVH
`define ADR_CTRL      4'h0
`define ADR_STATUS    4'h1
`define ADR_BUF       4'h2
`define ADR_OWN       4'h3
`define ADR_DIR_C     4'h4
`define ADR_DIR_D     4'h5
`define ADR_IRQ_FLAG  4'h6
`define ADR_IRQ_EN    4'h7
`define ADR_ROUTE     4'h8
`define CTL_EN        5
`define CTL_CKP       4
`define ST_P          4
`define ST_S          3
`define ST_RW         2
`define ST_BF         0
`define IRQ_BIT       3
`define DIR_C_SCL     5
`define DIR_C_SDA     4
`define DIR_D_SCL     3
`define DIR_D_SDA     2
`define MODE_SLV_IDLE 4'hb
`define MODE_SLV7_SP  4'he
`define MODE_SLV10_SP 4'hf
`define MODE_SLV7     4'h6
`define MODE_SLV10    4'h7
`define BITS_PER_BYTE 4'h8
`endif

// ==== src/i2c_fw_pkg.sv ====
package i2c_fw_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_lines_s;
  typedef enum logic [1:0] {
    SL_IDLE,
    SL_SHIFT,
    SL_ACK
  } slave_state_e;
endpackage

// ==== src/sync3.sv ====
`timescale 1ns/10ps
`default_nettype none
// three-stage input filter; output changes when stages two and three agree
module sync3 (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // resets high to match an idle pulled-up bus line
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/i2c_fw_master_port.sv ====
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_fw_params.svh"
module i2c_fw_master_port
  import i2c_fw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        pin_route_select,
  input  wire logic        scl_c_in,
  input  wire logic        sda_c_in,
  input  wire logic        scl_d_in,
  input  wire logic        sda_d_in,
  output logic             scl_c_oe,
  output logic             sda_c_oe,
  output logic             scl_d_oe,
  output logic             sda_d_oe,
  output logic             scl_c_out,
  output logic             sda_c_out,
  output logic             scl_d_out,
  output logic             sda_d_out,
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]   ctrl_q;
  logic [7:0]   own_q;
  logic [7:0]   buf_q;
  logic [7:0]   dir_c_q;
  logic [7:0]   dir_d_q;
  logic [7:0]   iflag_q;
  logic [7:0]   ien_q;
  logic         p_q;
  logic         s_q;
  logic         rw_q;
  logic         bf_q;
  logic         ack_q;
  logic         wait_q;
  logic         acc_wr;
  logic         acc_rd;
  logic [7:0]   shift_q;
  logic [3:0]   cnt_q;
  logic         addr_ph_q;
  slave_state_e st_q;
  i2c_lines_s   raw;
  i2c_lines_s   ln;
  i2c_lines_s   ln_q;

  //////////////////////////////////////////////////////////////////////////
  // pin routing and filtering
  assign raw.scl = pin_route_select ? scl_d_in : scl_c_in;
  assign raw.sda = pin_route_select ? sda_d_in : sda_c_in;

  sync3 u_sync_scl (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .din     (raw.scl),
    .dout    (ln.scl)
  );
  sync3 u_sync_sda (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .din     (raw.sda),
    .dout    (ln.sda)
  );

  //////////////////////////////////////////////////////////////////////////
  // bus condition decode
  wire enabled   = ctrl_q[`CTL_EN];
  wire [3:0] mode = ctrl_q[3:0];
  wire start_ev  = ln_q.scl & ln.scl & ln_q.sda & ~ln.sda;
  wire stop_ev   = ln_q.scl & ln.scl & ~ln_q.sda & ln.sda;
  wire scl_rise  = ~ln_q.scl & ln.scl;
  wire scl_fall  = ln_q.scl & ~ln.scl;
  // slave runs in every slave mode, also alongside the master (slave-idle
  // code only reports conditions)
  wire slave_on  = enabled & (mode == `MODE_SLV7 | mode == `MODE_SLV10 |
                              mode == `MODE_SLV7_SP | mode == `MODE_SLV10_SP);
  wire sp_irq_on = enabled & (mode == `MODE_SLV_IDLE |
                              mode == `MODE_SLV7_SP |
                              mode == `MODE_SLV10_SP);
  wire byte_done = slave_on & (st_q == SL_SHIFT) & scl_rise &
                   (cnt_q == `BITS_PER_BYTE - 4'h1);
  wire addr_hit  = addr_ph_q & ({shift_q[6:0], ln.sda} ==
                                {own_q[7:1], 1'b0} |
                                {shift_q[6:0], ln.sda} ==
                                {own_q[7:1], 1'b1});
  wire port_ev   = (sp_irq_on & (start_ev | stop_ev)) | byte_done;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ln_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      ln_q <= ln;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // start and stop flags, latest condition wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      p_q <= 1'b0;
      s_q <= 1'b0;
    end else if (!enabled) begin
      p_q <= 1'b0;
      s_q <= 1'b0;
    end else if (start_ev) begin
      s_q <= 1'b1;
      p_q <= 1'b0;
    end else if (stop_ev) begin
      p_q <= 1'b1;
      s_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // slave receiver: keeps listening even when our master lost arbitration
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= SL_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      addr_ph_q <= 1'b0;
      ack_q     <= 1'b0;
    end else if (!slave_on || stop_ev) begin
      st_q  <= SL_IDLE;
      ack_q <= 1'b0;
    end else if (start_ev) begin
      st_q      <= SL_SHIFT;
      cnt_q     <= 4'h0;
      addr_ph_q <= 1'b1;
      ack_q     <= 1'b0;
    end else begin
      case (st_q)
        SL_SHIFT: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], ln.sda};
            cnt_q   <= cnt_q + 4'h1;
            if (byte_done) begin
              ack_q <= addr_ph_q ? addr_hit : 1'b1;
              st_q  <= SL_ACK;
            end
          end
        end
        SL_ACK: begin
          // ack is driven from the falling edge after the eighth bit
          // until the falling edge after the ninth
          if (scl_fall && cnt_q == `BITS_PER_BYTE) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q != `BITS_PER_BYTE) begin
            st_q      <= ack_q ? SL_SHIFT : SL_IDLE;
            cnt_q     <= 4'h0;
            addr_ph_q <= 1'b0;
            ack_q     <= 1'b0;
          end
        end
        default: begin
          st_q <= SL_IDLE;
        end
      endcase
    end
  end

  wire ack_drive = (st_q == SL_ACK) & ack_q & (cnt_q != `BITS_PER_BYTE);

  //////////////////////////////////////////////////////////////////////////
  // receive buffer and full flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_q <= 8'h00;
      bf_q  <= 1'b0;
      rw_q  <= 1'b0;
    end else if (byte_done) begin
      buf_q <= {shift_q[6:0], ln.sda};
      bf_q  <= 1'b1;
      if (addr_ph_q) begin
        rw_q <= ln.sda;
      end
    end else if (acc_rd && avs_address == `ADR_BUF) begin
      bf_q <= 1'b0;
    end else if (acc_wr && avs_address == `ADR_BUF) begin
      buf_q <= avs_writedata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the access completes
  // effects land on the edge that completes the access; read data are
  // captured one edge earlier so they stand while waitrequest is low
  assign acc_wr = avs_write & ~avs_waitrequest;
  assign acc_rd = avs_read & ~avs_waitrequest;
  wire   rd_cap = avs_read & wait_q;
  wire [7:0] status = {3'b000, p_q, s_q, rw_q, 1'b0, bf_q};
  wire [7:0] rd_sel =
    (avs_address == `ADR_CTRL)     ? ctrl_q  :
    (avs_address == `ADR_STATUS)   ? status  :
    (avs_address == `ADR_BUF)      ? buf_q   :
    (avs_address == `ADR_OWN)      ? own_q   :
    (avs_address == `ADR_DIR_C)    ? dir_c_q :
    (avs_address == `ADR_DIR_D)    ? dir_d_q :
    (avs_address == `ADR_IRQ_FLAG) ? iflag_q :
    (avs_address == `ADR_IRQ_EN)   ? ien_q   :
    (avs_address == `ADR_ROUTE)    ? {7'h00, pin_route_select} : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q          <= 1'b1;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      wait_q          <= (avs_read | avs_write) ? ~wait_q : 1'b1;
      avs_waitrequest <= ~((avs_read | avs_write) & wait_q);
      avs_readdata    <= rd_cap ? {24'h00_0000, rd_sel} : 32'h0000_0000;
    end
  end

  // writable registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q  <= 8'h00;
      own_q   <= 8'h00;
      dir_c_q <= 8'hff;
      dir_d_q <= 8'hff;
      ien_q   <= 8'h00;
    end else if (acc_wr) begin
      if (avs_address == `ADR_CTRL) begin
        ctrl_q <= {2'b00, avs_writedata[5:0]};
      end else if (avs_address == `ADR_OWN) begin
        own_q <= avs_writedata[7:0];
      end else if (avs_address == `ADR_DIR_C) begin
        dir_c_q <= avs_writedata[7:0];
      end else if (avs_address == `ADR_DIR_D) begin
        dir_d_q <= avs_writedata[7:0];
      end else if (avs_address == `ADR_IRQ_EN) begin
        ien_q <= avs_writedata[7:0] & 8'h08;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky irq flag, write one to clear, new event beats the clear
  wire clr_hit = acc_wr & (avs_address == `ADR_IRQ_FLAG) &
                 avs_writedata[`IRQ_BIT];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      iflag_q <= 8'h00;
    end else if (port_ev) begin
      iflag_q[`IRQ_BIT] <= 1'b1;
    end else if (clr_hit) begin
      iflag_q[`IRQ_BIT] <= 1'b0;
    end
  end

  // level irq; a stop seen while busy sets the flag so enabling later fires
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(iflag_q & ien_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // open-drain drive: output always low, enable on the routed port while enabled when direction bit clear, sda also for ack
  wire sel_d = pin_route_select;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_c_oe  <= 1'b0;
      sda_c_oe  <= 1'b0;
      scl_d_oe  <= 1'b0;
      sda_d_oe  <= 1'b0;
      scl_c_out <= 1'b0;
      sda_c_out <= 1'b0;
      scl_d_out <= 1'b0;
      sda_d_out <= 1'b0;
    end else begin
      scl_c_oe <= enabled & ~sel_d & ~dir_c_q[`DIR_C_SCL];
      sda_c_oe <= enabled & ~sel_d &
                  (~dir_c_q[`DIR_C_SDA] | ack_drive);
      scl_d_oe <= enabled & sel_d & ~dir_d_q[`DIR_D_SCL];
      sda_d_oe <= enabled & sel_d &
                  (~dir_d_q[`DIR_D_SDA] | ack_drive);
      scl_c_out <= 1'b0;
      sda_c_out <= 1'b0;
      scl_d_out <= 1'b0;
      sda_d_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/i2c_fw_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_fw_props (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pin_route_select,
  input wire logic        scl_c_in,
  input wire logic        sda_c_in,
  input wire logic        scl_d_in,
  input wire logic        sda_d_in,
  input wire logic        scl_c_oe,
  input wire logic        sda_c_oe,
  input wire logic        scl_c_out,
  input wire logic        sda_c_out,
  input wire logic        scl_d_out,
  input wire logic        sda_d_out,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] lines_q;
  logic [3:0] quiet_q;
  wire  [3:0] lines = {scl_c_in, sda_c_in, scl_d_in, sda_d_in};
  // cycles since any pin moved; saturates so it never wraps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lines_q <= 4'hf;
      quiet_q <= 4'hf;
    end else begin
      lines_q <= lines;
      quiet_q <= (lines != lines_q) ? 4'h0
                 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  chk_wait_answer: assert property (s_req |=> s_ans)
    else $error("no answer one cycle after request");
  chk_wait_cause: assert property
    (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("answer without request");
  chk_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data outside answer");
  chk_out_low: assert property
    (!(scl_c_out || sda_c_out || scl_d_out || sda_d_out))
    else $error("pin output level not low");
  chk_oe_reset: assert property
    ($rose(rst_b) |-> !scl_c_oe && !sda_c_oe)
    else $error("pin driven after reset");
  chk_oe_cause: assert property
    ($rose(scl_c_oe) || $rose(sda_c_oe) |-> $past(avs_write)
     || $past(avs_write, 2) || $past(avs_write, 3) || quiet_q < 4'h8
     || $past(pin_route_select, 3) != pin_route_select)
    else $error("pin driven without cause");
  chk_irq_cause: assert property
    ($rose(irq) |-> $past(avs_write) || $past(avs_write, 2)
     || $past(avs_write, 3) || quiet_q < 4'he)
    else $error("irq without event");
  chk_irq_reset: assert property ($rose(rst_b) |-> !irq)
    else $error("irq set after reset");
endmodule
`default_nettype wire

// ==== dv/i2c_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_model (
  input  wire logic pin_route_select,
  input  wire logic scl_c_oe,
  input  wire logic sda_c_oe,
  input  wire logic scl_d_oe,
  input  wire logic sda_d_oe,
  output wire logic scl_c_in,
  output wire logic sda_c_in,
  output wire logic scl_d_in,
  output wire logic sda_d_in
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  // wired-and with pull-ups; the unrouted port only sees its pull-up
  assign scl_c_in = !scl_c_oe && (pin_route_select || scl_m);
  assign sda_c_in = !sda_c_oe && (pin_route_select || sda_m);
  assign scl_d_in = !scl_d_oe && (!pin_route_select || scl_m);
  assign sda_d_in = !sda_d_oe && (!pin_route_select || sda_m);
  wire sda_w = pin_route_select ? sda_d_in : sda_c_in;
  //////////////////////////////////////////////////////////////////////////
  // data falls while clock is high, then clock goes low
  task start_cond;
    #160 sda_m = 1'b0;
    #160 scl_m = 1'b0;
  endtask
  task stop_cond;
    #160 sda_m = 1'b0;
    #160 scl_m = 1'b1;
    #160 sda_m = 1'b1;
    #160;
  endtask
  // 320 ns link period; a one is sent by releasing the line
  task send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #40 sda_m = b[i];
      #120 scl_m = 1'b1;
      #160 scl_m = 1'b0;
    end
    #40 sda_m = 1'b1;
    #120 scl_m = 1'b1;
    // late sample: the slave's drive needs the filter delay to show
    #140 ack = sda_w;
    #20 scl_m = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        pin_route_select = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] rd;
  logic [7:0]  a, dc, dd;
  logic [3:0]  m;
  logic        ack, r;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, irq;
  wire         scl_c_in, sda_c_in, scl_d_in, sda_d_in;
  wire         scl_c_oe, sda_c_oe, scl_d_oe, sda_d_oe;
  wire         scl_c_out, sda_c_out, scl_d_out, sda_d_out;
  int          fails = 0, n_compared = 0, cyc = 0;
  logic [3:0]  modes [3] = '{4'hb, 4'he, 4'h6};
  i2c_fw_master_port u_i2c_fw_master_port (.*);
  i2c_bus_model u_i2c_bus_model (.*);
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      stop_test;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one access held until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] ad, input logic [7:0] d);
    avs_address <= ad;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input logic [3:0] ad, input logic [7:0] e);
    acc(1'b0, ad, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic wt;
    repeat (10) @(posedge ref_clk);
  endtask
  function automatic logic sp_irq(input logic [3:0] md);
    return md == 4'hb || md == 4'he || md == 4'hf;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1a8b));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rchk(4'h4, 8'hff);
    rchk(4'h5, 8'hff);
    rchk(4'h1, 8'h00);
    acc(1'b1, 4'h9, 8'h5a);
    rchk(4'h9, 8'h00);
    $display("test reset done");
    // start and stop per mode; irq only in the modes that report conditions
    for (int k = 0; k < 3; k++) begin
      m = modes[k];
      acc(1'b1, 4'h0, {4'h2, m});
      acc(1'b1, 4'h7, 8'h08);
      rchk(4'h1, 8'h00);
      u_i2c_bus_model.start_cond;
      wt;
      rchk(4'h1, 8'h08);
      `CHK(irq, sp_irq(m))
      acc(1'b1, 4'h6, 8'h08);
      wt;
      `CHK(irq, 1'b0)
      u_i2c_bus_model.stop_cond;
      wt;
      rchk(4'h1, 8'h10);
      `CHK(irq, sp_irq(m))
      acc(1'b1, 4'h6, 8'h08);
      acc(1'b1, 4'h0, {4'h0, m});
      rchk(4'h1, 8'h00);
    end
    $display("test start stop done");
    // masked flag, then enable while busy
    acc(1'b1, 4'h0, 8'h2b);
    acc(1'b1, 4'h7, 8'h00);
    u_i2c_bus_model.start_cond;
    wt;
    `CHK(irq, 1'b0)
    rchk(4'h6, 8'h08);
    acc(1'b1, 4'h6, 8'h08);
    rchk(4'h6, 8'h00);
    acc(1'b1, 4'h7, 8'h08);
    wt;
    `CHK(irq, 1'b0)
    u_i2c_bus_model.stop_cond;
    wt;
    `CHK(irq, 1'b1)
    $display("test busy enable done");
    // slave keeps receiving; acks only its own address
    a = {$urandom_range(127, 0), 1'b0};
    acc(1'b1, 4'h0, 8'h2e);
    acc(1'b1, 4'h3, a);
    for (int k = 0; k < 2; k++) begin
      u_i2c_bus_model.start_cond;
      acc(1'b1, 4'h6, 8'h08);
      u_i2c_bus_model.send_byte(a ^ {k[0], 7'h0}, ack);
      wt;
      `CHK(ack, k[0])
      if (k == 0)
        rchk(4'h2, a);
      `CHK(irq, 1'b1)
      u_i2c_bus_model.stop_cond;
      wt;
    end
    $display("test slave address done");
    // direction bits drive the routed pins low
    acc(1'b1, 4'h0, 8'h2b);
    for (int k = 0; k < 8; k++) begin
      dc = k ? $urandom : 8'h00;
      dd = k ? $urandom : 8'h00;
      r = $urandom_range(1, 0);
      pin_route_select <= r;
      acc(1'b1, 4'h4, dc);
      acc(1'b1, 4'h5, dd);
      wt;
      `CHK(r ? {scl_d_oe, sda_d_oe} : {scl_c_oe, sda_c_oe},
           r ? ~dd[3:2] : ~dc[5:4])
      rchk(4'h8, {7'h0, r});
    end
    // losing arbitration: both lines released by setting direction bits
    acc(1'b1, 4'h4, 8'hff);
    acc(1'b1, 4'h5, 8'hff);
    wt;
    `CHK({scl_c_oe, sda_c_oe, scl_d_oe, sda_d_oe}, 4'h0)
    $display("test pins done");
    stop_test;
  end
endmodule
bind i2c_fw_master_port i2c_fw_props u_i2c_fw_props (.*);
`default_nettype wire
